// file: core/crop_pkg.sv
package crop_pkg;
  // ----------------------------------------------------------------
  // sensor geometry and window limits
  // ----------------------------------------------------------------
  localparam int PIX_W = 12;
  localparam int SUM_W = 16;
  localparam logic [11:0] H_FULL_L = 12'd4000;
  localparam logic [11:0] V_FULL_L = 12'd3000;
  localparam logic [11:0] H_FULL_S = 12'd2832;
  localparam logic [11:0] V_FULL_S = 12'd2128;
  localparam logic [11:0] UHD_W = 12'd3840;
  localparam logic [11:0] UHD_H = 12'd2160;
  localparam logic [11:0] UHD_HOFF = 12'((4000 - 3840) / 2);
  localparam logic [11:0] UHD_VOFF = 12'((3000 - 2160) / 2);
  localparam logic [11:0] MIN_H = 12'd8;
  localparam logic [11:0] MIN_V = 12'd2;
  localparam logic [5:0] M_MAX = 6'd32;

  // ----------------------------------------------------------------
  // timing: conversion time per line, rounded up to whole clocks
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV10_NS = 9000;
  localparam int CONV12_NS = 20000;
  localparam logic [15:0] CONV10_CYC = 16'((CONV10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CONV12_CYC = 16'((CONV12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // averaging arithmetic and buffers
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV9_MUL = 16'd58255; // floor(x/9) exact for x < 65536
  localparam int DIV9_SH = 19;
  localparam int LB_DEPTH = 4096;
  localparam int LB_AW = 12;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {AVG_OFF, AVG_4, AVG_9} avg_e;

  typedef struct packed {
    logic [11:0] hoff;
    logic [11:0] voff;
    logic [11:0] hsize;
    logic [11:0] vsize;
  } win_s;

  typedef struct packed {
    win_s win;
    avg_e avg;
    logic cfa;
    logic [5:0] keep_n;
    logic [5:0] per_m;
  } cfg_s;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic sof;
    logic eol;
  } pix_in_s;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic sof;
    logic sol;
  } pix_out_s;

  localparam int POUT_W = $bits(pix_out_s);

  typedef struct packed {
    cfg_s cfg;
    logic [11:0] col;
    logic [11:0] row;
    logic [5:0] hsub;
    logic [5:0] vsub;
    logic [2:0] hcnt;
    logic [2:0] vcnt;
    logic [10:0] gx;
    logic [1:0][SUM_W-1:0] hsum;
    pix_out_s opix;
    logic ov;
    logic fpend;
    logic [11:0] ccols;
    logic [11:0] crows;
    logic [11:0] ocols;
    logic [11:0] orows;
    logic [15:0] lperiod;
    logic overlap;
  } crop_st_s;
endpackage : crop_pkg

// file: core/pix_fifo.sv
`timescale 1ns/1ps
module pix_fifo #(
  parameter int W = 14,
  parameter int D = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic [W-1:0] in_data, // write word
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  output logic [W-1:0] out_data, // head word
  output logic out_valid, // head word present
  input wire logic out_ready // reader takes head
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_s;

  fifo_st_s st_q, st_d;
  logic [W-1:0] mem [D];
  logic wr, rd;

  // ----------------------------------------------------------------
  // flags and pointers
  // ----------------------------------------------------------------
  assign in_ready = (st_q.cnt != (AW+1)'(D));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = mem[st_q.rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (wr) st_d.wp = st_q.wp + 1'b1;
    if (rd) st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) st_q <= '0;
    else st_q <= st_d;
  end

  // storage has no reset; the count guards reads
  always_ff @(posedge clk_sys) begin
    if (wr) mem[st_q.wp] <= in_data;
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_q.cnt <= (AW+1)'(D)) else $error("fifo count beyond depth");
endmodule : pix_fifo

// file: core/window_crop_and_decimation.sv
// Function
// - one window each for configuration A, B
// - large sensor preset window 3840 by 2160
// - offsets and sizes set per axis independently
// - window never below 8 by 2
// - window clamped to full sensor resolution
// - all columns read, only window rows read
// - two sensor rows form one line
// - line period at least conversion time
// - triggered dual mode stops exposure overlap
// - alternating uses configuration A line period
// - averaging four or nine into one
// - mono 4:1 sums four, divides by four
// - color averaging combines same-color pixels only
// - 9:1 uses 3x3 mono, wider color area
// - averaging works on full image or window
// - averaging still reads every window row
// - averaging and subsampling may run together
// - keep N of every M, both axes
// - output size counted from emitted pixels
`timescale 1ns/1ps
module window_crop_and_decimation (
  input wire logic clk_sys, // pixel clock
  input wire logic rstn, // sync reset, active low
  input wire crop_pkg::win_s win_a, // window of configuration A
  input wire crop_pkg::win_s win_b, // window of configuration B
  input wire logic frame_sel, // 0 selects A, 1 selects B
  input wire logic uhd_preset, // use the preset window, large sensor only
  input wire logic sensor_large, // larger sensor variant
  input wire logic cfa_present, // color filter array fitted
  input wire crop_pkg::avg_e avg_mode, // averaging ratio
  input wire logic [5:0] keep_n, // kept run length
  input wire logic [5:0] period_m, // subsampling period
  input wire logic bits12, // 12-bit conversion depth
  input wire logic dual_mode, // alternating A/B frames
  input wire logic trig_dual, // triggered dual mode
  input wire logic [15:0] line_period_a, // line period A, clocks
  input wire logic [15:0] line_period_b, // line period B, clocks
  input wire crop_pkg::pix_in_s in_pix, // pixel from readout
  input wire logic in_valid, // in_pix valid
  output logic in_ready, // block accepts in_pix
  output crop_pkg::pix_out_s out_pix, // decimated pixel
  output logic out_valid, // out_pix valid
  input wire logic out_ready, // grabber side takes out_pix
  output logic [10:0] rd_first_line, // first line to read
  output logic [10:0] rd_line_count, // lines to read
  output logic [15:0] line_period, // applied line period
  output logic expose_overlap, // exposure may overlap readout
  output logic [11:0] out_cols, // output width, last frame
  output logic [11:0] out_rows // output height, last frame
);
  import crop_pkg::*;

  crop_st_s st_q, st_d;
  // one sum per output column and row phase
  logic [SUM_W-1:0] lbuf [LB_DEPTH];
  cfg_s cfg_n, cur;
  win_s w;
  logic [11:0] hfull, vfull, col, row;
  logic [5:0] hsub, vsub;
  logic [2:0] hcnt, vcnt, span, step;
  logic [10:0] gx;
  logic [1:0][SUM_W-1:0] hs;
  logic acc, sub_en, in_h, in_v, keep_h, keep_v, take, par, rpar;
  logic h_first, h_last, v_first, v_last, emit, lb_we, fifo_ready;
  logic pix_fifo_ready; // fifo takes the stage
  logic [LB_AW-1:0] lb_addr;
  logic [SUM_W-1:0] lb_rd, lb_wd, tot;
  logic [31:0] prod9;
  logic [PIX_W-1:0] avg_val;
  logic [10:0] oc;
  logic [15:0] lp_sel, lp_min;

  // ----------------------------------------------------------------
  // window selection and limiting
  // ----------------------------------------------------------------
  // offsets are clamped after the size so the window always fits
  always_comb begin
    hfull = sensor_large ? H_FULL_L : H_FULL_S;
    vfull = sensor_large ? V_FULL_L : V_FULL_S;
    w = frame_sel ? win_b : win_a;
    if (uhd_preset && sensor_large) begin
      w = '{hoff: UHD_HOFF, voff: UHD_VOFF, hsize: UHD_W, vsize: UHD_H};
    end
    if (w.hsize < MIN_H) w.hsize = MIN_H;
    if (w.vsize < MIN_V) w.vsize = MIN_V;
    if (w.hsize > hfull) w.hsize = hfull;
    if (w.vsize > vfull) w.vsize = vfull;
    if (w.hoff > hfull - w.hsize) w.hoff = hfull - w.hsize;
    if (w.voff > vfull - w.vsize) w.voff = vfull - w.vsize;
    // settings travel as one word, latched at sof
    cfg_n = '{win: w, avg: avg_mode, cfa: cfa_present, keep_n: keep_n, per_m: period_m};
  end

  // ----------------------------------------------------------------
  // position and decimation decisions for the incoming pixel
  // ----------------------------------------------------------------
  assign fifo_ready = pix_fifo_ready;
  // take only when the stage can hold a result
  assign in_ready = !st_q.ov || fifo_ready;
  assign acc = in_valid && in_ready;

  // a start of frame restarts every counter with the fresh settings
  always_comb begin
    cur = (acc && in_pix.sof) ? cfg_n : st_q.cfg;
    col = in_pix.sof ? '0 : st_q.col;
    row = in_pix.sof ? '0 : st_q.row;
    hsub = in_pix.sof ? '0 : st_q.hsub;
    vsub = in_pix.sof ? '0 : st_q.vsub;
    hcnt = in_pix.sof ? '0 : st_q.hcnt;
    vcnt = in_pix.sof ? '0 : st_q.vcnt;
    gx = in_pix.sof ? '0 : st_q.gx;
    hs = st_q.hsum;
    // subsampling only acts on a legal period, M above N and in range
    sub_en = (cur.per_m > cur.keep_n) && (cur.per_m <= M_MAX);
    // every column arrives; only window columns are used
    in_h = (13'(col) >= 13'(cur.win.hoff)) &&
           (13'(col) < 13'(cur.win.hoff) + 13'(cur.win.hsize));
    in_v = row < cur.win.vsize;
    keep_h = !sub_en || (hsub < cur.keep_n);
    keep_v = !sub_en || (vsub < cur.keep_n);
    take = acc && in_h && in_v && keep_h && keep_v;
    // group span; colour interleaves two phases
    span = (cur.avg == AVG_9) ? 3'd3 : 3'd2;
    if (cur.cfa) span = 3'(span << 1);
    step = cur.cfa ? 3'd2 : 3'd1;
    // colour phase in column and row
    par = cur.cfa && hcnt[0];
    rpar = cur.cfa && vcnt[0];
    // group edges along each axis
    h_first = hcnt < step;
    h_last = hcnt >= span - step;
    v_first = vcnt < step;
    v_last = vcnt >= span - step;
    oc = cur.cfa ? {gx[9:0], par} : gx; // same-color groups side by side
  end

  // ----------------------------------------------------------------
  // averaging datapath
  // ----------------------------------------------------------------
  // one line of partial column sums; colour uses the row parity half
  always_comb begin
    lb_addr = {rpar, oc};
    lb_rd = lbuf[lb_addr];
    tot = (h_first ? '0 : hs[par]) + SUM_W'(in_pix.data);
    // stored sum joins at the group end only, once
    if (!v_first && h_last) tot = tot + lb_rd;
    lb_wd = tot;
    lb_we = take && (cur.avg != AVG_OFF) && h_last && !v_last;
    prod9 = 32'(tot) * 32'(DIV9_MUL);
    if (cur.avg == AVG_9) avg_val = PIX_W'(prod9 >> DIV9_SH);
    else avg_val = PIX_W'(tot >> 2);
    emit = take && ((cur.avg == AVG_OFF) || (h_last && v_last));
  end

  always_ff @(posedge clk_sys) begin
    if (lb_we) lbuf[lb_addr] <= lb_wd;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // fifo taking the word frees the stage
    if (st_q.ov && fifo_ready) st_d.ov = 1'b0;
    // line timing tracks its inputs every clock
    lp_sel = (dual_mode || !frame_sel) ? line_period_a : line_period_b;
    lp_min = bits12 ? CONV12_CYC : CONV10_CYC;
    st_d.lperiod = (lp_sel < lp_min) ? lp_min : lp_sel;
    st_d.overlap = !(dual_mode && trig_dual);
    // counters move only on an accepted pixel
    if (acc) begin
      st_d.cfg = cur;
      st_d.col = col + 12'd1;
      st_d.row = row;
      st_d.hsub = hsub;
      st_d.vsub = vsub;
      st_d.hcnt = hcnt;
      st_d.vcnt = vcnt;
      st_d.gx = gx;
      // new frame publishes the last size
      if (in_pix.sof) begin
        st_d.fpend = 1'b1;
        st_d.ocols = st_q.ccols;
        st_d.orows = st_q.crows;
        st_d.ccols = '0;
        st_d.crows = '0;
      end
      // phase counts window columns only
      if (in_h && sub_en) st_d.hsub = (hsub == cur.per_m - 6'd1) ? '0 : hsub + 6'd1;
      // kept pixel steps group, closed group steps gx
      if (take) begin
        st_d.hsum[par] = tot;
        st_d.hcnt = (hcnt == span - 3'd1) ? '0 : hcnt + 3'd1;
        if (cur.avg == AVG_OFF || hcnt == span - 3'd1) st_d.gx = gx + 11'd1;
      end
      // word waits in the stage until the fifo takes it
      if (emit) begin
        st_d.ov = 1'b1;
        st_d.opix.data = (cur.avg == AVG_OFF) ? in_pix.data : avg_val;
        st_d.opix.sof = st_d.fpend;
        st_d.opix.sol = (oc == '0);
        st_d.fpend = 1'b0;
        // width counts on the first output line
        if (oc == '0) st_d.crows = st_d.crows + 12'd1;
        if (st_d.crows == 12'd1) st_d.ccols = st_d.ccols + 12'd1;
      end
      // line end: restart columns, step the row counters
      if (in_pix.eol) begin
        st_d.col = '0;
        st_d.hsub = '0;
        st_d.hcnt = '0;
        st_d.gx = '0;
        if (in_v) begin
          st_d.row = row + 12'd1;
          if (sub_en) st_d.vsub = (vsub == cur.per_m - 6'd1) ? '0 : vsub + 6'd1;
          // dropped rows leave the group row alone
          if (keep_v) st_d.vcnt = (vcnt == span - 3'd1) ? '0 : vcnt + 3'd1;
        end
      end
    end
  end

  // reset keeps line period legal before a frame
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.overlap <= 1'b1;
      st_q.lperiod <= CONV10_CYC;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // readout request and status outputs
  // ----------------------------------------------------------------
  // two rows convert together, so the readout is asked for whole lines
  assign rd_first_line = cfg_n.win.voff[11:1];
  // count rounds up: an odd window keeps its last row
  assign rd_line_count = 11'((13'(cfg_n.win.vsize) + 13'd1) >> 1);
  assign line_period = st_q.lperiod;
  assign expose_overlap = st_q.overlap;
  assign out_cols = st_q.ocols;
  assign out_rows = st_q.orows;

  // ----------------------------------------------------------------
  // output buffer toward the grabber
  // ----------------------------------------------------------------
  logic [POUT_W-1:0] fifo_out;

  // fifo rides out stalls; readout waits only when full
  pix_fifo #(.W(POUT_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(st_q.opix),
    .in_valid(st_q.ov),
    .in_ready(pix_fifo_ready),
    .out_data(fifo_out),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );
  assign out_pix = pix_out_s'(fifo_out);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // window limits hold for any selection
  win_min_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cfg_n.win.hsize >= MIN_H && cfg_n.win.vsize >= MIN_V) else $error("window too small");
  win_fit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    13'(cfg_n.win.hoff) + 13'(cfg_n.win.hsize) <= 13'(hfull)) else $error("window too wide");
  uhd_size_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    uhd_preset && sensor_large |-> cfg_n.win.hsize == UHD_W && cfg_n.win.vsize == UHD_H)
    else $error("preset window wrong");
  line_min_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 line_period >= (($past(bits12)) ? CONV12_CYC : CONV10_CYC))
    else $error("line period below conversion time");
  dual_period_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    dual_mode && line_period_a >= CONV12_CYC |=> line_period == $past(line_period_a))
    else $error("dual mode not using period A");
  trig_overlap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    dual_mode && trig_dual |=> !expose_overlap) else $error("overlap in triggered dual");
  skip_pixel_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc && !take && (!st_q.ov || fifo_ready) |=> !st_q.ov) else $error("skipped pixel sent");
  pass_data_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    take && cur.avg == AVG_OFF |=> st_q.ov && st_q.opix.data == $past(in_pix.data))
    else $error("pass-through pixel lost");
  reset_clear_a: assert property (@(posedge clk_sys)
    !rstn |=> st_q.col == '0 && st_q.row == '0 && !st_q.ov) else $error("reset left state");
  div9_exact_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    emit && cur.avg == AVG_9 |-> avg_val == PIX_W'(32'(tot) / 32'd9))
    else $error("nine-way average inexact");
  sof_restart_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc && in_pix.sof && !in_pix.eol |=> st_q.col == 12'd1 && st_q.row == '0)
    else $error("sof left counters running");
endmodule : window_crop_and_decimation

// file: test/pix_partner.sv
`timescale 1ns/1ps
module pix_partner
  import crop_pkg::*;
(
  input wire logic clk_sys, // pixel clock
  output crop_pkg::pix_in_s in_pix, // pixel towards the block
  output logic in_valid, // in_pix valid
  input wire logic in_ready, // block accepts in_pix
  input wire crop_pkg::pix_out_s out_pix, // decimated pixel
  input wire logic out_valid, // out_pix valid
  output logic out_ready // grabber takes out_pix
);
  import crop_pkg::*;
  pix_out_s got[$];
  logic stall = 1'b0;
  logic [2:0] scnt = 3'h0;
  int refused = 0;
  initial begin
    in_pix = '0;
    in_valid = 1'b0;
    out_ready = 1'b1;
  end

  // -------------------------------------------------------------
  // readout side: deterministic pixel values, high to stress sums
  // -------------------------------------------------------------
  function automatic logic [11:0] pix(input int r, input int c);
    return 12'hfff - 12'((c * 3 + r * 5) % 1024);
  endfunction : pix

  // every column of each window row is delivered, sof first, eol last
  task automatic send_frame(input int rows, input int cols);
    @(posedge clk_sys);
    for (int r = 0; r < rows; r++) begin
      for (int c = 0; c < cols; c++) begin
        in_pix <= pix_in_s'{pix(r, c), (r == 0 && c == 0), (c == cols - 1)};
        in_valid <= 1'b1;
        do @(posedge clk_sys); while (in_ready !== 1'b1);
      end
    end
    in_valid <= 1'b0;
    in_pix.data <= ~in_pix.data; // released data must not look valid
  endtask : send_frame

  // -------------------------------------------------------------
  // grabber side: collects output, may stall to back up the fifo
  // -------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back(out_pix);
    end
    if (in_valid && in_ready === 1'b0) begin
      refused <= refused + 1;
    end
    scnt <= scnt + 3'h1;
    out_ready <= !stall || (scnt == 3'h7);
  end
endmodule : pix_partner

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import crop_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  win_s win_a = '{12'h000, 12'h000, 12'h008, 12'h002};
  win_s win_b = '{12'h000, 12'h000, 12'h008, 12'h002};
  logic frame_sel = 1'b0;
  logic uhd_preset = 1'b0;
  logic sensor_large = 1'b0;
  logic cfa_present = 1'b0;
  avg_e avg_mode = AVG_OFF;
  logic [5:0] keep_n = 6'h00;
  logic [5:0] period_m = 6'h00;
  logic bits12 = 1'b0;
  logic dual_mode = 1'b0;
  logic trig_dual = 1'b0;
  logic [15:0] line_period_a = 16'h0000;
  logic [15:0] line_period_b = 16'h0000;
  pix_in_s in_pix;
  logic in_valid, in_ready, out_valid, out_ready, expose_overlap;
  pix_out_s out_pix;
  logic [10:0] rd_first_line, rd_line_count;
  logic [15:0] line_period;
  logic [11:0] out_cols, out_rows;
  int errors = 0;
  int comparisons = 0;
  int prev_cols = 0;
  int prev_rows = 0;
  pix_out_s exp_q[$];

  always #10 clk_sys = ~clk_sys;

  window_crop_and_decimation uut (.clk_sys(clk_sys), .rstn(rstn), .win_a(win_a),
    .win_b(win_b), .frame_sel(frame_sel), .uhd_preset(uhd_preset),
    .sensor_large(sensor_large), .cfa_present(cfa_present), .avg_mode(avg_mode),
    .keep_n(keep_n), .period_m(period_m), .bits12(bits12), .dual_mode(dual_mode),
    .trig_dual(trig_dual), .line_period_a(line_period_a), .line_period_b(line_period_b),
    .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_pix(out_pix),
    .out_valid(out_valid), .out_ready(out_ready), .rd_first_line(rd_first_line),
    .rd_line_count(rd_line_count), .line_period(line_period),
    .expose_overlap(expose_overlap), .out_cols(out_cols), .out_rows(out_rows));

  pix_partner partner (.clk_sys(clk_sys), .in_pix(in_pix), .in_valid(in_valid),
    .in_ready(in_ready), .out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready));

  // -------------------------------------------------------------
  // comparison and closing
  // -------------------------------------------------------------
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // -------------------------------------------------------------
  // helpers: config, probe frame, reference model
  // -------------------------------------------------------------
  // offsets kept even and N, M even with M above N, as the caller must
  task automatic set_mode(input avg_e a, input logic cfa, input int n, input int m,
                          input win_s w);
    @(posedge clk_sys);
    avg_mode <= a;
    cfa_present <= cfa;
    keep_n <= 6'(n);
    period_m <= 6'(m);
    win_a <= w;
  endtask : set_mode

  // one sof pixel makes the block latch the config just set
  task automatic probe();
    partner.send_frame(1, 1);
    repeat (10) @(posedge clk_sys);
  endtask : probe

  // expected output: subsample on window coordinates, then average
  task automatic build_exp(input int hs, vs, k, cfa, n, m, ho);
    int kc[$];
    int kr[$];
    int sum, ic, ir;
    logic [15:0] v;
    exp_q.delete();
    for (int c = 0; c < hs; c++) if (m == 0 || c % m < n) kc.push_back(c);
    for (int r = 0; r < vs; r++) if (m == 0 || r % m < n) kr.push_back(r);
    for (int orr = 0; orr < kr.size() / k; orr++) begin
      for (int oc = 0; oc < kc.size() / k; oc++) begin
        sum = 0;
        for (int i = 0; i < k; i++) begin
          for (int j = 0; j < k; j++) begin
            ir = (cfa && k > 1) ? (orr / 2) * 2 * k + orr % 2 + 2 * i : orr * k + i;
            ic = (cfa && k > 1) ? (oc / 2) * 2 * k + oc % 2 + 2 * j : oc * k + j;
            sum += int'(partner.pix(kr[ir], ho + kc[ic]));
          end
        end
        v = 16'((k == 1) ? sum : (k == 2) ? sum / 4 : sum / 9);
        exp_q.push_back(pix_out_s'{v[11:0], (orr == 0 && oc == 0), (oc == 0)});
      end
    end
    prev_cols = (prev_cols << 16) | (kc.size() / k); // low half: this frame
    prev_rows = (prev_rows << 16) | (kr.size() / k);
  endtask : build_exp

  // sends one window frame, waits for all output, compares in order
  task automatic data_frame(input int hs, vs, k, cfa, n, m, ho, input logic chk_size);
    int t;
    partner.got.delete();
    build_exp(hs, vs, k, cfa, n, m, ho);
    partner.send_frame(vs, int'(H_FULL_S));
    t = 0;
    while (partner.got.size() < exp_q.size() && t < 5000) begin
      @(posedge clk_sys);
      t++;
    end
    repeat (20) @(posedge clk_sys);
    check_val(16'(partner.got.size()), 16'(exp_q.size()), "pixel count");
    foreach (exp_q[i]) begin
      if (i < partner.got.size()) check_val(16'(partner.got[i]), 16'(exp_q[i]), "pixel");
    end
    // the sof of this frame published the size of the one before
    if (chk_size) check_val(16'(out_cols), 16'(prev_cols >> 16), "out_cols");
    if (chk_size) check_val(16'(out_rows), 16'(prev_rows >> 16), "out_rows");
  endtask : data_frame

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    check_val(16'(out_valid), 16'h0000, "reset out_valid");
    check_val(16'(in_ready), 16'h0001, "reset in_ready");
    check_val(line_period, CONV10_CYC, "reset line period");
    check_val(16'(expose_overlap), 16'h0001, "reset overlap");
    check_val(16'({out_cols, out_rows} != 24'h0), 16'h0000, "reset sizes");
  endtask : t_reset

  task automatic t_windows();
    @(posedge clk_sys);
    win_a <= '{12'h000, 12'h0c8, 12'h008, 12'h00a};
    win_b <= '{12'h000, 12'h064, 12'h008, 12'hfa0};
    probe();
    check_val(16'(rd_first_line), 16'h0064, "window a first line");
    check_val(16'(rd_line_count), 16'h0005, "window a lines");
    frame_sel <= 1'b1;
    probe();
    check_val(16'(rd_first_line), 16'h0000, "window b first line");
    check_val(16'(rd_line_count), 16'h0428, "window b lines");
    sensor_large <= 1'b1;
    uhd_preset <= 1'b1;
    probe();
    check_val(16'(rd_first_line), 16'h00d2, "preset first line");
    check_val(16'(rd_line_count), 16'h0438, "preset lines");
    sensor_large <= 1'b0;
    uhd_preset <= 1'b0;
    frame_sel <= 1'b0;
  endtask : t_windows

  task automatic t_line_timing();
    line_period_a <= 16'h000a;
    bits12 <= 1'b1;
    probe();
    check_val(line_period, CONV12_CYC, "12-bit minimum");
    line_period_a <= 16'h05dc;
    line_period_b <= 16'h0bb8;
    frame_sel <= 1'b1;
    probe();
    check_val(line_period, 16'h0bb8, "period b");
    dual_mode <= 1'b1;
    probe();
    check_val(line_period, 16'h05dc, "alternating uses a");
    check_val(16'(expose_overlap), 16'h0001, "overlap free run");
    trig_dual <= 1'b1;
    probe();
    check_val(16'(expose_overlap), 16'h0000, "no overlap triggered");
    dual_mode <= 1'b0;
    trig_dual <= 1'b0;
    frame_sel <= 1'b0;
  endtask : t_line_timing

  // window asked below the minimum: 4 by 1 widens to 8 by 2
  task automatic t_min_window();
    set_mode(AVG_OFF, 1'b0, 0, 0, '{12'h004, 12'h000, 12'h004, 12'h001});
    data_frame(8, 2, 1, 0, 0, 0, 4, 1'b0);
    check_val(16'(rd_line_count), 16'h0001, "min window lines");
  endtask : t_min_window

  task automatic t_averaging();
    set_mode(AVG_4, 1'b0, 0, 0, '{12'h000, 12'h000, 12'h008, 12'h004});
    data_frame(8, 4, 2, 0, 0, 0, 0, 1'b1);
    set_mode(AVG_9, 1'b0, 0, 0, '{12'h000, 12'h000, 12'h009, 12'h003});
    data_frame(9, 3, 3, 0, 0, 0, 0, 1'b1);
    check_val(16'(rd_line_count), 16'h0002, "averaged window lines");
    set_mode(AVG_4, 1'b1, 0, 0, '{12'h000, 12'h000, 12'h008, 12'h004});
    data_frame(8, 4, 2, 1, 0, 0, 0, 1'b1);
    set_mode(AVG_9, 1'b1, 0, 0, '{12'h000, 12'h000, 12'h00c, 12'h006});
    data_frame(12, 6, 3, 1, 0, 0, 0, 1'b1);
  endtask : t_averaging

  task automatic t_subsample();
    set_mode(AVG_OFF, 1'b0, 2, 6, '{12'h000, 12'h000, 12'h00c, 12'h004});
    data_frame(12, 4, 1, 0, 2, 6, 0, 1'b1);
    set_mode(AVG_4, 1'b0, 2, 4, '{12'h000, 12'h000, 12'h010, 12'h004});
    data_frame(16, 4, 2, 0, 2, 4, 0, 1'b1);
  endtask : t_subsample

  // a slow grabber fills the fifo, the block must hold off readout
  task automatic t_fifo_full();
    set_mode(AVG_OFF, 1'b0, 0, 0, '{12'h002, 12'h000, 12'h040, 12'h002});
    partner.stall <= 1'b1;
    data_frame(64, 2, 1, 0, 0, 0, 2, 1'b1);
    partner.stall <= 1'b0;
    check_val(16'(partner.refused > 0), 16'h0001, "fifo refused input");
    check_val(16'(out_valid), 16'h0000, "fifo drained");
  endtask : t_fifo_full

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_windows();
    t_line_timing();
    t_min_window();
    t_averaging();
    t_subsample();
    t_fifo_full();
    final_report();
  end

  // the whole run needs about 83k clocks; a hang stops near 95k
  initial begin
    #(20 * 95000);
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end
endmodule : testbench
